// ==== shared/io_bank_pkg.sv ====
// Purpose: Shared constants for the I/O index/data port bank.
// Assumes: 16-bit I/O addresses, 8-bit data, one 20 MHz clock.
// Notes: Port addresses are byte addresses in I/O space.
package io_bank_pkg;

	// Port addresses
	localparam logic [15:0] PIN_PORT_ADDR = 16'h0c52; // Multiplexed pin port
	localparam logic [15:0] EXT_IDX_ADDR = 16'h0cd0; // Extended Power_mgmt_main_index
	localparam logic [15:0] EXT_DATA_ADDR = 16'h0cd1; // Extended Power_mgmt_main_data
	localparam logic [15:0] RAM_IDX_ADDR = 16'h0cd4; // Scratch RAM index
	localparam logic [15:0] RAM_DATA_ADDR = 16'h0cd5; // Scratch RAM data
	localparam logic [15:0] MAIN_IDX_ADDR = 16'h0cd6; // Main Power_mgmt_main_index
	localparam logic [15:0] MAIN_DATA_ADDR = 16'h0cd7; // Main Power_mgmt_main_data

	// Pin-port mode selector codes
	localparam logic [1:0] MODE_READBACK = 2'h0; // Pin input levels
	localparam logic [1:0] MODE_ENABLE = 2'h1; // Output enables, 0 drives
	localparam logic [1:0] MODE_LEVEL = 2'h2; // Output levels
	localparam logic [1:0] MODE_LOCK = 2'h3; // Ownership lock bits

	// Reset values
	localparam logic [7:0] INDEX_RESET = 8'h00; // All index registers
	localparam logic [7:0] ENABLE_N_RESET = 8'hff; // All pins tristate
	localparam logic [7:0] LEVEL_RESET = 8'h00; // Output levels low
	localparam logic [7:0] LOCK_RESET = 8'h00; // Host owns every pin
	localparam logic [7:0] UNMAPPED_READ = 8'hff; // Floating-bus answer

	// Scratch RAM geometry
	localparam int RAM_DEPTH = 256; // Bytes of scratch RAM

endpackage

// ==== hw/scratch_ram.sv ====
// Purpose: 256-byte scratch RAM kept alive by the standby well.
// Assumes: Ordinary reset never reaches this array.
// Notes: Resume-well reset clears every byte while it is held.
module scratch_ram
	import io_bank_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic resumeRst_n, // Resume-well reset pin, active low
	input wire logic [7:0] addr, // Byte location
	input wire logic wrEn, // Write strobe
	input wire logic [7:0] wrData, // Byte to store
	output logic [7:0] rdData // Byte at addr, combinational
);

	logic [7:0] mem [RAM_DEPTH]; // Storage array
	logic rstMeta_r; // First synchroniser stage
	logic rstSync_r; // Second stage, active low clear

	// Reset synchroniser: clear starts at once, ends two edges after release
	// Ordinary reset stays out, so a resume-well reset that comes
	// together with it still wipes the array
	always_ff @(posedge clock or negedge resumeRst_n) begin
		if (!resumeRst_n) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	// Array ignores arst_n on purpose so contents ride out resets
	always_ff @(posedge clock) begin
		if (!rstSync_r) begin // (R10)
			for (int i = 0; i < RAM_DEPTH; i++) begin
				mem[i] <= 8'h00;
			end
		end else if (wrEn) begin
			mem[addr] <= wrData; // (R9)
		end
	end

	assign rdData = mem[addr]; // (R9)

endmodule // scratch_ram

// ==== hw/io_index_data_port_bank.sv ====
// Purpose: I/O port bank with pin port and three index/data pairs.
// Assumes: Host I/O strobes are one-cycle pulses on this clock.
// Notes: Mode selector and PM register spaces live outside this block.
// Notes on behaviour
// (R1) Mode 00 reads pin input levels
// (R2) Mode 01 accesses enables, 0 drives
// (R3) Mode 10 accesses levels, driven when enabled
// (R4) Mode 11 accesses eight lock bits
// (R5) Locked pins follow microcontroller, host writes ignored
// (R6) Lock also freezes pull resistor configuration
// (R7) Extended index holds 8-bit register selector
// (R8) Extended data forwarded to selected register
// (R9) Scratch index selects byte, data accesses it
// (R10) Scratch RAM survives resets, cleared by resume
// (R11) Main index selects, main data forwards
// (R12) Host sets mode via client management register
// (R13) Index registers never auto-increment
module io_index_data_port_bank
	import io_bank_pkg::*;
(
	input wire logic clock, // 20 MHz system clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic resumeRst_n, // Resume-well reset, active low
	input wire logic [15:0] ioAddr, // I/O port address
	input wire logic ioWrEn, // Write request pulse
	input wire logic ioRdEn, // Read request pulse
	input wire logic [7:0] ioWrData, // Write data
	output logic [7:0] ioRdData, // Read answer
	output logic ioRdValid, // Read answer valid pulse
	input wire logic [1:0] pinMode, // Mode selector from client mgmt
	input wire logic [7:0] mcuDrive, // Microcontroller enables, 1 drives
	input wire logic [7:0] mcuLevel, // Microcontroller output levels
	input wire logic [7:0] gpioIn, // Pin input levels
	output logic [7:0] gpioOut, // Pin output levels
	output logic [7:0] gpioOe, // Pin output enables, 1 drives
	output logic [7:0] pullCfgLock, // Freezes pull resistor config
	output logic [7:0] extIndex, // Extended PM register selector
	output logic extWrStb, // Extended PM write pulse
	output logic extRdStb, // Extended PM read pulse
	output logic [7:0] extWrData, // Extended PM write data
	input wire logic [7:0] extRdData, // Extended PM read data
	output logic [7:0] mainIndex, // Main PM register selector
	output logic mainWrStb, // Main PM write pulse
	output logic mainRdStb, // Main PM read pulse
	output logic [7:0] mainWrData, // Main PM write data
	input wire logic [7:0] mainRdData // Main PM read data
);

	// Host-side pin state and indexes
	logic [7:0] enableN_r, enableN_nxt; // Host enables, 0 drives
	logic [7:0] level_r, level_nxt; // Host output levels
	logic [7:0] lock_r; // Ownership lock bits
	logic [7:0] ramIndex_r; // Scratch RAM index
	logic [7:0] gpioMeta_r, gpioSync_r; // Pin input synchroniser
	logic [7:0] ramRdData; // Scratch byte at index
	logic [15:0] pendAddr_r; // Read waiting for its answer
	logic pendRd_r; // Read pending flag
	logic [7:0] rdMux; // Answer selection
	logic [7:0] pinRead; // Pin port view by mode
	logic [7:0] oeNxt, outNxt; // Per-pin output next values

	// Address decode
	wire hitPin = (ioAddr == PIN_PORT_ADDR);
	wire wrPin = ioWrEn && hitPin;
	wire wrExtIdx = ioWrEn && (ioAddr == EXT_IDX_ADDR);
	wire wrRamIdx = ioWrEn && (ioAddr == RAM_IDX_ADDR);
	wire wrRamData = ioWrEn && (ioAddr == RAM_DATA_ADDR);
	wire wrMainIdx = ioWrEn && (ioAddr == MAIN_IDX_ADDR);
	wire extAcc = (ioAddr == EXT_DATA_ADDR);
	wire mainAcc = (ioAddr == MAIN_DATA_ADDR);

	// Host writes to locked pins keep the old bit
	assign enableN_nxt = (wrPin && pinMode == MODE_ENABLE) ? // (R2)
		((ioWrData & ~lock_r) | (enableN_r & lock_r)) : enableN_r; // (R5)
	assign level_nxt = (wrPin && pinMode == MODE_LEVEL) ? // (R3)
		((ioWrData & ~lock_r) | (level_r & lock_r)) : level_r; // (R5)

	// Per-pin owner select: microcontroller wins while locked
	for (genvar i = 0; i < 8; i++) begin : gPin
		assign oeNxt[i] = lock_r[i] ? mcuDrive[i] : ~enableN_r[i]; // (R5)
		assign outNxt[i] = lock_r[i] ? mcuLevel[i] : level_r[i]; // (R3)
	end

	// Pin port read view
	assign pinRead = (pinMode == MODE_READBACK) ? gpioSync_r : // (R1)
		(pinMode == MODE_ENABLE) ? enableN_r : // (R2)
		(pinMode == MODE_LEVEL) ? level_r : lock_r; // (R4)

	// Answer mux uses the pending address a cycle after the request
	assign rdMux = (pendAddr_r == PIN_PORT_ADDR) ? pinRead :
		(pendAddr_r == EXT_IDX_ADDR) ? extIndex :
		(pendAddr_r == EXT_DATA_ADDR) ? extRdData : // (R8)
		(pendAddr_r == RAM_IDX_ADDR) ? ramIndex_r :
		(pendAddr_r == RAM_DATA_ADDR) ? ramRdData : // (R9)
		(pendAddr_r == MAIN_IDX_ADDR) ? mainIndex :
		(pendAddr_r == MAIN_DATA_ADDR) ? mainRdData : // (R11)
		UNMAPPED_READ;

	scratch_ram i_scratch_ram (
		.clock(clock),
		.resumeRst_n(resumeRst_n),
		.addr(ramIndex_r),
		.wrEn(wrRamData),
		.wrData(ioWrData),
		.rdData(ramRdData)
	);

	// Pin input synchroniser, first stage read only by the second
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gpioMeta_r <= 8'h00;
			gpioSync_r <= 8'h00;
		end else begin
			gpioMeta_r <= gpioIn;
			gpioSync_r <= gpioMeta_r;
		end
	end

	// Pin state and outputs; outputs lag the pin state by one edge, host writes by two
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			enableN_r <= ENABLE_N_RESET;
			level_r <= LEVEL_RESET;
			lock_r <= LOCK_RESET;
			gpioOe <= 8'h00;
			gpioOut <= LEVEL_RESET;
			pullCfgLock <= LOCK_RESET;
		end else begin
			enableN_r <= enableN_nxt;
			level_r <= level_nxt;
			if (wrPin && pinMode == MODE_LOCK)
				lock_r <= ioWrData; // (R4)
			gpioOe <= oeNxt; // (R2)
			gpioOut <= outNxt; // (R3)
			pullCfgLock <= lock_r; // (R6)
		end
	end

	// Index registers change only on their own port writes
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			extIndex <= INDEX_RESET;
			ramIndex_r <= INDEX_RESET;
			mainIndex <= INDEX_RESET;
		end else begin
			if (wrExtIdx)
				extIndex <= ioWrData; // (R7) (R13)
			if (wrRamIdx)
				ramIndex_r <= ioWrData; // (R9) (R13)
			if (wrMainIdx)
				mainIndex <= ioWrData; // (R11) (R13)
		end
	end

	// Forwarded strobes and read pipeline
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			extWrStb <= 1'b0;
			extRdStb <= 1'b0;
			extWrData <= 8'h00;
			mainWrStb <= 1'b0;
			mainRdStb <= 1'b0;
			mainWrData <= 8'h00;
			pendAddr_r <= 16'h0000;
			pendRd_r <= 1'b0;
			ioRdData <= 8'h00;
			ioRdValid <= 1'b0;
		end else begin
			extWrStb <= ioWrEn && extAcc; // (R8)
			extRdStb <= ioRdEn && extAcc; // (R8)
			mainWrStb <= ioWrEn && mainAcc; // (R11)
			mainRdStb <= ioRdEn && mainAcc; // (R11)
			if (ioWrEn) begin
				extWrData <= ioWrData;
				mainWrData <= ioWrData;
			end
			pendRd_r <= ioRdEn;
			if (ioRdEn)
				pendAddr_r <= ioAddr;
			ioRdValid <= pendRd_r;
			if (pendRd_r)
				ioRdData <= rdMux;
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	a_readback_pins: assert property ((ioRdEn && hitPin && // (R1)
		pinMode == MODE_READBACK) ##1 (pinMode == MODE_READBACK)
		|=> ioRdValid && ioRdData == $past(gpioSync_r))
		else $error("Pin readback mismatch");
	a_enable_drive: assert property (##1 (!lock_r[0] && // (R2)
		$past(!lock_r[0])) |-> gpioOe[0] == !$past(enableN_r[0]))
		else $error("Enable bit does not steer driver");
	a_level_write: assert property ((wrPin && // (R3)
		pinMode == MODE_LEVEL && !lock_r[1])
		|=> level_r[1] == $past(ioWrData[1]))
		else $error("Level write lost");
	a_lock_write: assert property ((wrPin && // (R4)
		pinMode == MODE_LOCK) |=> lock_r == $past(ioWrData)
		##1 pullCfgLock == $past(ioWrData, 2))
		else $error("Lock write not applied");
	a_locked_hold: assert property ((wrPin && lock_r[2]) // (R5)
		|=> $stable(enableN_r[2]) && $stable(level_r[2]))
		else $error("Host changed locked pin");
	a_locked_owner: assert property (lock_r[3] |=> // (R5)
		gpioOut[3] == $past(mcuLevel[3]) &&
		gpioOe[3] == $past(mcuDrive[3]))
		else $error("Locked pin not owned by microcontroller");
	a_pull_lock: assert property (##1 // (R6)
		pullCfgLock == $past(lock_r))
		else $error("Pull lock does not follow lock bits");
	a_ext_forward: assert property ((ioWrEn && extAcc) // (R8)
		|=> extWrStb && extWrData == $past(ioWrData) &&
		$stable(extIndex))
		else $error("Extended write not forwarded");
	a_ram_roundtrip: assert property ((wrRamData && resumeRst_n) // (R9)
		##1 (ioRdEn && ioAddr == RAM_DATA_ADDR && !wrRamIdx &&
		resumeRst_n) |-> ##2 ioRdValid &&
		ioRdData == $past(ioWrData, 3))
		else $error("Scratch byte not returned");
	a_main_read: assert property ((ioRdEn && mainAcc) // (R11)
		|=> mainRdStb ##1 ioRdValid && ioRdData == $past(mainRdData))
		else $error("Main data read not forwarded");
	a_index_hold: assert property ((ioWrEn || ioRdEn) && // (R13)
		!wrExtIdx && !wrMainIdx && !wrRamIdx |=> $stable(extIndex) &&
		$stable(mainIndex) && $stable(ramIndex_r))
		else $error("Index moved without index write");

	c_lock_set: cover property (wrPin && pinMode == MODE_LOCK);
	c_ext_read: cover property (extRdStb ##1 ioRdValid);
	c_ram_write: cover property (wrRamData);
	c_unmapped: cover property (ioRdValid && ioRdData == UNMAPPED_READ);

endmodule // io_index_data_port_bank

// ==== verif/host_model.sv ====
// Purpose: Host model issuing single I/O reads and writes.
// Assumes: One request at a time, launched at a rising edge.
// Notes: Released address and data lines show the inverse value.
module host_model
	import io_bank_pkg::*;
(
	input wire logic clock, // System clock
	input wire logic [7:0] ioRdData, // Read answer
	input wire logic ioRdValid, // Answer valid pulse
	output logic [15:0] ioAddr, // Port address
	output logic ioWrEn, // Write pulse
	output logic ioRdEn, // Read pulse
	output logic [7:0] ioWrData // Write data
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial begin
		ioAddr = 16'h0000;
		ioWrEn = 1'b0;
		ioRdEn = 1'b0;
		ioWrData = 8'h00;
	end
	// Write pulse, taken one edge after launch
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		ioAddr <= a;
		ioWrData <= d;
		ioWrEn <= 1'b1;
		@(posedge clock);
		ioWrEn <= 1'b0;
		ioAddr <= ~a; // No stale address after release
		ioWrData <= ~d;
	endtask
	// Read pulse; answer sampled mid-cycle so no edge race
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clock);
		ioAddr <= a;
		ioRdEn <= 1'b1;
		@(posedge clock);
		ioRdEn <= 1'b0;
		ioAddr <= ~a;
		d = 8'hxx; // Unknown unless an answer arrives
		for (int n = 0; n < 4; n++) begin
			@(negedge clock);
			if (ioRdValid === 1'b1) begin
				d = ioRdData;
				break;
			end
		end
	endtask
endmodule // host_model

// ==== verif/tb_io_index_data_port_bank.sv ====
// Purpose: Self-checking bench for the I/O port bank.
// Assumes: Host model drives the I/O side; PM spaces are arrays here.
// Notes: One task per scenario, each judges its own results.
module tb_io_index_data_port_bank
	import io_bank_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, arst_n, resumeRst_n; // Clock and resets
	logic [1:0] pinMode; // Mode selector
	logic [7:0] mcuDrive, mcuLevel, gpioIn; // Pin side inputs
	logic [7:0] extRdData, mainRdData; // PM read answers
	logic [15:0] ioAddr; // Host bus
	logic ioWrEn, ioRdEn, ioRdValid;
	logic [7:0] ioWrData, ioRdData;
	logic [7:0] gpioOut, gpioOe, pullCfgLock; // Pin outputs
	logic [7:0] extIndex, extWrData, mainIndex, mainWrData;
	logic extWrStb, extRdStb, mainWrStb, mainRdStb;
	logic [7:0] extMem [256]; // Extended PM space stand-in
	logic [7:0] mainMem [256]; // Main PM space stand-in
	int mismatches = 0;
	int nTests = 0;
	int rdStbs = 0; // Forwarded PM read strobes seen
	io_index_data_port_bank i_io_index_data_port_bank(.clock(clock),
		.arst_n(arst_n), .resumeRst_n(resumeRst_n), .ioAddr(ioAddr),
		.ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .ioWrData(ioWrData),
		.ioRdData(ioRdData), .ioRdValid(ioRdValid), .pinMode(pinMode),
		.mcuDrive(mcuDrive), .mcuLevel(mcuLevel), .gpioIn(gpioIn),
		.gpioOut(gpioOut), .gpioOe(gpioOe), .pullCfgLock(pullCfgLock),
		.extIndex(extIndex), .extWrStb(extWrStb), .extRdStb(extRdStb),
		.extWrData(extWrData), .extRdData(extRdData),
		.mainIndex(mainIndex), .mainWrStb(mainWrStb),
		.mainRdStb(mainRdStb), .mainWrData(mainWrData),
		.mainRdData(mainRdData));
	host_model i_host_model(.clock(clock), .ioRdData(ioRdData),
		.ioRdValid(ioRdValid), .ioAddr(ioAddr), .ioWrEn(ioWrEn),
		.ioRdEn(ioRdEn), .ioWrData(ioWrData));
	// PM spaces answer at the selected index
	assign extRdData = extMem[extIndex];
	assign mainRdData = mainMem[mainIndex];
	always @(posedge clock) begin
		if (extWrStb) extMem[extIndex] <= extWrData;
		if (mainWrStb) mainMem[mainIndex] <= mainWrData;
		if (extRdStb || mainRdStb) rdStbs <= rdStbs + 1;
	end
	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		nTests++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", nTests, mismatches);
		if (mismatches == 0 && nTests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Reset values, unmapped read
	task automatic t_reset;
		logic [7:0] d;
		i_host_model.rd(EXT_IDX_ADDR, d);
		chk(d, INDEX_RESET);
		i_host_model.rd(MAIN_IDX_ADDR, d);
		chk(d, INDEX_RESET);
		i_host_model.rd(16'h0cd2, d);
		chk(d, UNMAPPED_READ);
		chk(gpioOe, 8'h00);
		$display("t_reset done");
	endtask
	// Index then two data writes; index must not move
	task automatic t_pm(input logic [15:0] ia, input logic [7:0] ix);
		logic [7:0] d;
		int base;
		base = rdStbs;
		i_host_model.wr(ia, ix);
		i_host_model.wr(ia + 16'h0001, 8'h11);
		i_host_model.wr(ia + 16'h0001, ~ix);
		i_host_model.rd(ia + 16'h0001, d);
		chk(d, ~ix);
		i_host_model.rd(ia, d);
		chk(d, ix);
		chk(ia == EXT_IDX_ADDR ? extMem[ix] : mainMem[ix], ~ix);
		chk(8'(rdStbs - base), 8'h01);
		$display("t_pm done");
	endtask
	// Scratch RAM survives ordinary reset, not resume-well reset
	task automatic t_ram;
		logic [7:0] d;
		i_host_model.wr(RAM_IDX_ADDR, 8'hff);
		i_host_model.wr(RAM_DATA_ADDR, 8'hc3);
		i_host_model.wr(RAM_IDX_ADDR, 8'h00);
		i_host_model.wr(RAM_DATA_ADDR, 8'h3c);
		i_host_model.rd(RAM_DATA_ADDR, d);
		chk(d, 8'h3c);
		@(posedge clock) arst_n <= 1'b0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		i_host_model.rd(RAM_IDX_ADDR, d);
		chk(d, INDEX_RESET);
		i_host_model.wr(RAM_IDX_ADDR, 8'hff);
		i_host_model.rd(RAM_DATA_ADDR, d);
		chk(d, 8'hc3);
		@(posedge clock) resumeRst_n <= 1'b0;
		repeat (5) @(posedge clock);
		resumeRst_n <= 1'b1;
		i_host_model.rd(RAM_DATA_ADDR, d);
		chk(d, 8'h00);
		$display("t_ram done");
	endtask
	// All four modes, then locked pins resist the host
	task automatic t_pins;
		logic [7:0] d;
		@(posedge clock) pinMode <= MODE_ENABLE;
		i_host_model.wr(PIN_PORT_ADDR, 8'hf0);
		repeat (3) @(posedge clock);
		chk(gpioOe, 8'h0f);
		i_host_model.rd(PIN_PORT_ADDR, d);
		chk(d, 8'hf0);
		@(posedge clock) pinMode <= MODE_LEVEL;
		i_host_model.wr(PIN_PORT_ADDR, 8'ha5);
		repeat (3) @(posedge clock);
		chk(gpioOut & gpioOe, 8'h05);
		@(posedge clock) pinMode <= MODE_READBACK;
		gpioIn <= 8'h3c;
		repeat (3) @(posedge clock);
		i_host_model.rd(PIN_PORT_ADDR, d);
		chk(d, 8'h3c);
		// Pins 0, 2 and 3 go to the microcontroller, only pin 3 driven
		@(posedge clock) pinMode <= MODE_LOCK;
		mcuDrive <= 8'h08;
		mcuLevel <= 8'h00;
		i_host_model.wr(PIN_PORT_ADDR, 8'h0d);
		@(posedge clock) pinMode <= MODE_ENABLE;
		i_host_model.wr(PIN_PORT_ADDR, 8'hff);
		i_host_model.rd(PIN_PORT_ADDR, d);
		chk(d, 8'hf2);
		@(posedge clock) pinMode <= MODE_LEVEL;
		i_host_model.wr(PIN_PORT_ADDR, 8'hff);
		i_host_model.rd(PIN_PORT_ADDR, d);
		chk(d, 8'hf7);
		repeat (3) @(posedge clock);
		chk(gpioOe, 8'h08);
		chk(gpioOut & 8'h0d, 8'h00);
		chk(pullCfgLock, 8'h0d);
		@(posedge clock) pinMode <= MODE_LOCK;
		i_host_model.rd(PIN_PORT_ADDR, d);
		chk(d, 8'h0d);
		$display("t_pins done");
	endtask
	// Watchdog, far beyond the roughly 116 cycles needed
	initial begin
		repeat (5000) @(posedge clock);
		mismatches++;
		finish_test();
	end
	// Main sequence
	initial begin
		arst_n = 1'b0;
		resumeRst_n = 1'b0;
		pinMode = MODE_READBACK;
		mcuDrive = 8'h00;
		mcuLevel = 8'h00;
		gpioIn = 8'h00;
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		resumeRst_n <= 1'b1;
		t_reset();
		t_pm(EXT_IDX_ADDR, 8'h5a);
		t_pm(MAIN_IDX_ADDR, 8'hff);
		t_ram();
		t_pins();
		finish_test();
	end
endmodule // tb_io_index_data_port_bank
